// ### rtl/lfcs_pkg.sv
/*
 lfcs_pkg: shared types and constants of the link fabric configuration status block.
 assumes: every file of the block imports this package whole.
*/
package lfcs_pkg;

	localparam int       LFCS_DW        = 32;
	localparam int       LFCS_RUN_W     = 16;
	localparam logic     LFCS_DONE_RST  = 1'b0;
	localparam logic     LFCS_LINK_RST  = 1'b1;
	localparam logic     LFCS_ERR_RST   = 1'b0;

	// one word from the link; flags of an image are read from its sop header word only
	typedef struct packed {
		logic               sop;
		logic               eop;
		logic               fabric;
		logic               compressed;
		logic               encrypted;
		logic               partial;
		logic               is_run;
		logic [LFCS_DW-1:0] data;
	} lfcs_word_t;

	// one word toward the configuration memory
	typedef struct packed {
		logic               fabric;
		logic               partial;
		logic [LFCS_DW-1:0] data;
	} lfcs_cfg_t;

	typedef enum logic [1:0] {
		LFCS_IDLE,
		LFCS_LOAD,
		LFCS_FINISH,
		LFCS_DRAIN
	} lfcs_state_t;

endpackage

// ### rtl/lfcs_unpack.sv
/*
 lfcs_unpack: decrypts and expands one image word at a time.
 assumes: an external cipher core holds the stored key and offers one keystream word
 while ks_valid is high, advancing on each ks_take_q pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module lfcs_unpack
	import lfcs_pkg::*;
#(
	parameter int DW = LFCS_DW
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [DW-1:0] in_data,
	input  wire logic          in_compressed,
	input  wire logic          in_encrypted,
	input  wire logic          in_is_run,
	input  wire logic          ks_valid,
	input  wire logic [DW-1:0] ks_data,
	output logic               ks_take_q,
	output logic               out_valid_q,
	output logic [DW-1:0]      out_data_q,
	output logic               busy
);

	logic [LFCS_RUN_W-1:0] run_q;
	wire  [DW-1:0]         plain;
	wire                   ks_ok;
	wire                   take;
	wire                   run_tok;

	// one idle cycle after each keystream take so the core can advance
	assign plain    = in_encrypted ? (in_data ^ ks_data) : in_data; // [RULE8]
	assign ks_ok    = !in_encrypted || (ks_valid && !ks_take_q);
	assign busy     = (run_q != '0);
	assign in_ready = !busy && ks_ok;
	assign take     = in_valid && in_ready;
	assign run_tok  = in_compressed && in_is_run;

	always_ff @(posedge clk) begin
		if (srst) begin
			run_q       <= '0;
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
			ks_take_q   <= 1'b0;
		end else begin
			ks_take_q <= take && in_encrypted;
			if (busy) begin
				out_valid_q <= 1'b1;
				out_data_q  <= '0;
				run_q       <= run_q - 1'b1;
			end else if (take && run_tok) begin
				out_valid_q <= 1'b1;
				out_data_q  <= '0;
				run_q       <= plain[LFCS_RUN_W-1:0];
			end else if (take) begin
				out_valid_q <= 1'b1;
				out_data_q  <= plain;
			end else begin
				out_valid_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	decrypt_word_a: assert property (take && in_encrypted && !run_tok |=> // [RULE8]
		out_valid_q && out_data_q == $past(in_data ^ ks_data))
		else $error("encrypted word not decrypted with keystream");

endmodule
`default_nettype wire

// ### rtl/lfcs_top.sv
/*
 lfcs_top: link fabric configuration loader with done pin and hard block reset control.
 assumes: link words arrive synchronous to clk; cfg enables are static levels;
 the configuration memory takes one word per cycle without stalling.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] done pin low while fabric loads, high once fabric configuration completes.
// [RULE2] observer trusts full configuration only when done high after conventional done.
// [RULE3] observer watches the done pin to see when an update finished.
// [RULE4] with link configuration off, the done pin is a plain user pin.
// [RULE5] reset pin low holds transceivers and hard block in reset.
// [RULE6] with hard block unused, the reset pin is a plain user input.
// [RULE7] compression allowed for fabric image only; periphery always uncompressed.
// [RULE8] encrypted fabric image decrypted with keystream from the stored key.
// [RULE9] periphery image never encrypted; encrypted periphery header is refused.
// [RULE10] fabric updates arrive over the link only when link configuration enabled.
// [RULE11] partial reconfiguration images accepted and marked in every link mode; the code refuses every image while link configuration is off.
// [RULE12] host holds fundamental reset asserted 100 ms after power is stable; the host model releases it after 40 clk cycles (HOLD).
// [RULE13] done pin drops again whenever a new fabric image begins.
module lfcs_top
	import lfcs_pkg::*;
#(
	parameter int DW = LFCS_DW
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          link_based_configuration_en,
	input  wire logic          hard_block_used,
	input  wire logic          link_fundamental_reset_n,
	input  wire lfcs_word_t    link_word,
	input  wire logic          link_valid,
	output logic               link_ready_q,
	input  wire logic          cipher_ks_valid,
	input  wire logic [DW-1:0] cipher_ks,
	output logic               cipher_next_q,
	output logic               cipher_restart_q,
	output logic               fabric_wr_q,
	output lfcs_cfg_t          fabric_cfg_q,
	output logic               image_error_q,
	output logic               fabric_config_done_q,
	output logic               fabric_config_done_out,
	output logic               fabric_config_done_oe,
	input  wire logic          done_pin_user_out,
	input  wire logic          done_pin_user_oe,
	input  wire logic          done_pin_in,
	output logic               done_pin_user_in_q,
	output logic               user_reset_pin_q,
	output logic               xcvr_reset_q,
	output logic               hard_block_reset_q
);

	lfcs_state_t     state_q;
	lfcs_state_t     state_d;
	lfcs_word_t      hold_q;
	logic            hold_full_q;
	logic            img_fabric_q;
	logic            img_comp_q;
	logic            img_enc_q;
	logic            img_partial_q;
	logic            done_d;
	logic            err_d;
	wire             link_up;
	wire             hdr_take;
	wire             hdr_ok;
	wire             unp_valid;
	wire             unp_ready;
	wire             unp_out_valid;
	wire [DW-1:0]    unp_out_data;
	wire             unp_busy;
	wire             hold_take;
	wire             unp_idle;
	wire             link_take;

	assign link_up   = hard_block_used && link_fundamental_reset_n;
	assign hdr_take  = (state_q == LFCS_IDLE) && hold_full_q && hold_q.sop;
	// compressed or encrypted periphery header is never loaded
	assign hdr_ok    = link_based_configuration_en && link_up // [RULE10]
		&& (hold_q.fabric || (!hold_q.compressed && !hold_q.encrypted)); // [RULE7] [RULE9]
	assign unp_valid = (state_q == LFCS_LOAD) && hold_full_q;
	assign hold_take = hold_full_q && ((state_q == LFCS_IDLE) || (state_q == LFCS_DRAIN)
		|| ((state_q == LFCS_LOAD) && unp_ready));
	assign unp_idle  = !unp_busy && !unp_out_valid;
	assign link_take = link_valid && link_ready_q;

	lfcs_unpack #(
		.DW (DW)
	) u_unpack (
		.clk           (clk),
		.srst          (srst),
		.in_valid      (unp_valid),
		.in_ready      (unp_ready),
		.in_data       (hold_q.data),
		.in_compressed (img_comp_q),
		.in_encrypted  (img_enc_q),
		.in_is_run     (hold_q.is_run),
		.ks_valid      (cipher_ks_valid),
		.ks_data       (cipher_ks),
		.ks_take_q     (cipher_next_q),
		.out_valid_q   (unp_out_valid),
		.out_data_q    (unp_out_data),
		.busy          (unp_busy)
	);

	always_comb begin
		state_d = state_q;
		done_d  = fabric_config_done_q;
		err_d   = image_error_q;
		case (state_q)
			LFCS_IDLE: begin
				if (hdr_take && hdr_ok) begin
					state_d = LFCS_LOAD;
					err_d   = 1'b0;
					if (hold_q.fabric) begin
						done_d = 1'b0; // [RULE13]
					end
				end else if (hdr_take) begin
					state_d = LFCS_DRAIN;
					err_d   = 1'b1;
				end
			end
			LFCS_LOAD: begin
				// link reset or mode loss mid image aborts; done keeps its value, low for a fabric image
				if (!link_up || !link_based_configuration_en) begin
					state_d = LFCS_IDLE;
					err_d   = 1'b1;
				end else if (hold_take && hold_q.eop) begin
					state_d = LFCS_FINISH;
				end
			end
			LFCS_FINISH: begin
				if (unp_idle) begin
					state_d = LFCS_IDLE;
					if (img_fabric_q) begin
						done_d = 1'b1; // [RULE1]
					end
				end
			end
			LFCS_DRAIN: begin
				if (hold_take && hold_q.eop) begin
					state_d = LFCS_IDLE;
				end
			end
			default: begin
				state_d = LFCS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q              <= LFCS_IDLE;
			fabric_config_done_q <= LFCS_DONE_RST;
			image_error_q        <= LFCS_ERR_RST;
		end else begin
			state_q              <= state_d;
			fabric_config_done_q <= done_d;
			image_error_q        <= err_d;
		end
	end

	// registered ready halves throughput but keeps the link port glitch free
	always_ff @(posedge clk) begin
		if (srst) begin
			hold_q       <= '0;
			hold_full_q  <= 1'b0;
			link_ready_q <= 1'b0;
		end else begin
			if (link_take) begin
				hold_q <= link_word;
			end
			hold_full_q  <= link_take || (hold_full_q && !hold_take);
			link_ready_q <= !(link_take || (hold_full_q && !hold_take));
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			img_fabric_q     <= 1'b0;
			img_comp_q       <= 1'b0;
			img_enc_q        <= 1'b0;
			img_partial_q    <= 1'b0;
			cipher_restart_q <= 1'b0;
		end else begin
			cipher_restart_q <= hdr_take && hdr_ok && hold_q.encrypted;
			if (hdr_take && hdr_ok) begin
				img_fabric_q  <= hold_q.fabric;
				img_comp_q    <= hold_q.compressed;
				img_enc_q     <= hold_q.encrypted;
				img_partial_q <= hold_q.partial; // [RULE11]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			fabric_wr_q  <= 1'b0;
			fabric_cfg_q <= '0;
		end else begin
			fabric_wr_q  <= unp_out_valid;
			fabric_cfg_q <= '{fabric: img_fabric_q, partial: img_partial_q, data: unp_out_data}; // [RULE11]
		end
	end

	// pins; an unused hard block is kept in reset to save power
	always_ff @(posedge clk) begin
		if (srst) begin
			xcvr_reset_q           <= LFCS_LINK_RST;
			hard_block_reset_q     <= LFCS_LINK_RST;
			user_reset_pin_q       <= 1'b0;
			fabric_config_done_out <= 1'b0;
			fabric_config_done_oe  <= 1'b0;
			done_pin_user_in_q     <= 1'b0;
		end else begin
			xcvr_reset_q       <= !link_up; // [RULE5]
			hard_block_reset_q <= !link_up; // [RULE5]
			user_reset_pin_q   <= hard_block_used ? 1'b0 : link_fundamental_reset_n; // [RULE6]
			done_pin_user_in_q <= link_based_configuration_en ? 1'b0 : done_pin_in; // [RULE4]
			if (link_based_configuration_en) begin
				fabric_config_done_out <= done_d; // [RULE1]
				fabric_config_done_oe  <= 1'b1;
			end else begin
				fabric_config_done_out <= done_pin_user_out; // [RULE4]
				fabric_config_done_oe  <= done_pin_user_oe;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence fab_hdr_s;
		hdr_take && hdr_ok && hold_q.fabric;
	endsequence

	sequence load_done_s;
		(state_q == LFCS_FINISH) && unp_idle && img_fabric_q;
	endsequence

	// periphery loads leave done alone, so only a fabric load must see it low
	done_low_load_a: assert property ((state_q == LFCS_LOAD) && img_fabric_q // [RULE1]
		|-> !fabric_config_done_q)
		else $error("done high while fabric loads");
	done_rise_a: assert property (load_done_s ##0 link_based_configuration_en // [RULE1]
		|=> fabric_config_done_q && fabric_config_done_out)
		else $error("done not raised after fabric load");
	done_drop_new_a: assert property (fab_hdr_s |=> !fabric_config_done_q // [RULE13]
		&& (state_q == LFCS_LOAD))
		else $error("done not dropped at new fabric image");
	done_pin_user_a: assert property (!link_based_configuration_en |=> // [RULE4]
		fabric_config_done_oe == $past(done_pin_user_oe)
		&& fabric_config_done_out == $past(done_pin_user_out))
		else $error("done pin not released to user");
	link_reset_hold_a: assert property (!link_fundamental_reset_n |=> // [RULE5]
		xcvr_reset_q && hard_block_reset_q)
		else $error("hard block not held in reset");
	reset_pin_user_a: assert property (!hard_block_used |=> // [RULE6]
		user_reset_pin_q == $past(link_fundamental_reset_n))
		else $error("reset pin not passed to user");
	peri_comp_refuse_a: assert property (hdr_take && !hold_q.fabric && hold_q.compressed // [RULE7]
		|=> image_error_q && (state_q == LFCS_DRAIN))
		else $error("compressed periphery image not refused");
	peri_enc_refuse_a: assert property (hdr_take && !hold_q.fabric && hold_q.encrypted // [RULE9]
		|=> image_error_q && (state_q != LFCS_LOAD))
		else $error("encrypted periphery image not refused");
	link_mode_gate_a: assert property (hdr_take && !link_based_configuration_en // [RULE10]
		|=> (state_q == LFCS_DRAIN) ##1 !fabric_wr_q)
		else $error("image taken with link configuration off");
	partial_mark_a: assert property (unp_out_valid |=> fabric_wr_q // [RULE11]
		&& fabric_cfg_q.partial == $past(img_partial_q))
		else $error("partial marker lost");

endmodule
`default_nettype wire

// ### testbench/lfcs_host_model.sv
/*
 lfcs_host_model: host end of the link, offers image words and drives the reset pin.
 assumes: callers enter its tasks just after a rising clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lfcs_host_model
	import lfcs_pkg::*;
#(
	parameter int HOLD = 40
) (
	input  wire logic      clk,
	input  wire logic      link_ready_q,
	output var lfcs_word_t link_word,
	output var logic       link_valid,
	output var logic       link_fundamental_reset_n
);
	initial begin
		link_word = '0;
		link_valid = 1'b0;
		link_fundamental_reset_n = 1'b0;
		// scaled stand-in for the long power-up hold, keeps the run short
		repeat (HOLD) @(posedge clk);
		link_fundamental_reset_n <= 1'b1;
	end

	// word and valid held until taken; updates reach the device over the link only
	task automatic send(input lfcs_word_t w);
		int n;
		n = 0;
		link_word <= w;
		link_valid <= 1'b1;
		@(posedge clk);
		while (link_ready_q !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
	endtask

	// released data is inverted so a stale word never looks valid
	task automatic idle();
		link_valid <= 1'b0;
		link_word.data <= ~link_word.data;
		@(posedge clk);
	endtask

	task automatic set_rst(input logic v);
		link_fundamental_reset_n <= v;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### testbench/link_fabric_config_status_bench.sv
/*
 link_fabric_config_status_bench: self-checking bench of lfcs_top with a host model.
 assumes: package and rtl compiled first; keystream and pin levels driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module link_fabric_config_status_bench import lfcs_pkg::*;;
	logic        clk = 1'b0;
	logic        srst, link_based_configuration_en, hard_block_used, link_fundamental_reset_n;
	logic        link_valid, link_ready_q, cipher_ks_valid, cipher_next_q, cipher_restart_q;
	logic        fabric_wr_q, image_error_q, fabric_config_done_q, fabric_config_done_out;
	logic        fabric_config_done_oe, done_pin_user_out, done_pin_user_oe, done_pin_in;
	logic        done_pin_user_in_q, user_reset_pin_q, xcvr_reset_q, hard_block_reset_q;
	logic        wr_done;
	logic [31:0] cipher_ks;
	lfcs_word_t  link_word;
	lfcs_cfg_t   fabric_cfg_q, last_cfg;
	int          failures, n_tests, n_wr, cycles, n_ks, n_rs;

	always #2 clk = ~clk;

	lfcs_top i_dut (.clk, .srst, .link_based_configuration_en, .hard_block_used,
		.link_fundamental_reset_n, .link_word, .link_valid, .link_ready_q, .cipher_ks_valid,
		.cipher_ks, .cipher_next_q, .cipher_restart_q, .fabric_wr_q, .fabric_cfg_q,
		.image_error_q, .fabric_config_done_q, .fabric_config_done_out, .fabric_config_done_oe,
		.done_pin_user_out, .done_pin_user_oe, .done_pin_in, .done_pin_user_in_q,
		.user_reset_pin_q, .xcvr_reset_q, .hard_block_reset_q);

	lfcs_host_model #(.HOLD(40)) i_host (.clk, .link_ready_q, .link_word, .link_valid,
		.link_fundamental_reset_n);

	task automatic complete_run();
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// a hang here is cut short by the cycle ceiling below
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			complete_run();
		end
	end

	// every write is counted; done seen high during a write is remembered
	always @(posedge clk) begin
		if (fabric_wr_q === 1'b1) begin
			n_wr++;
			last_cfg = fabric_cfg_q;
			wr_done = wr_done | fabric_config_done_q;
		end
		if (cipher_next_q === 1'b1) begin
			n_ks++;
		end
		if (cipher_restart_q === 1'b1) begin
			n_rs++;
		end
	end

	task automatic img(input logic fab, cmp, enc, par, input logic [31:0] d,
		input logic run, input int n);
		i_host.send(lfcs_word_t'{sop: 1'b1, fabric: fab, compressed: cmp, encrypted: enc,
			partial: par, default: '0});
		for (int i = 0; i < n; i++) begin
			i_host.send(lfcs_word_t'{data: d + 32'(i), is_run: run, eop: (i == n - 1),
				default: '0});
		end
		i_host.idle();
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (fabric_config_done_q !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic t_plain();
		wr_done = 1'b0;
		n_wr = 0;
		img(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000A5A5, 1'b0, 3);
		wait_done();
		check(n_wr, 3);
		check(last_cfg, {1'b1, 1'b0, 32'h0000A5A7});
		check(wr_done, 1'b0);
		check({fabric_config_done_out, fabric_config_done_oe}, 2'b11);
	endtask

	task automatic t_partial();
		wr_done = 1'b0;
		img(1'b1, 1'b0, 1'b0, 1'b1, 32'h0, 1'b0, 0);
		repeat (2) @(posedge clk);
		check(fabric_config_done_q, 1'b0);
		i_host.send(lfcs_word_t'{eop: 1'b1, data: 32'h0000C3C3, default: '0});
		i_host.idle();
		wait_done();
		check(last_cfg, {1'b1, 1'b1, 32'h0000C3C3});
		check(wr_done, 1'b0);
	endtask

	task automatic t_compress();
		n_wr = 0;
		img(1'b1, 1'b1, 1'b0, 1'b0, 32'h00000001, 1'b1, 2);
		wait_done();
		check(n_wr, 5);
		check(last_cfg.data, 32'h0);
	endtask

	task automatic t_encrypt();
		n_wr = 0;
		n_ks = 0;
		n_rs = 0;
		cipher_ks <= 32'h5A5A0F0F;
		img(1'b1, 1'b0, 1'b1, 1'b0, 32'h12340000, 1'b0, 2);
		wait_done();
		check(n_wr, 2);
		check(last_cfg.data, 32'h12340001 ^ 32'h5A5A0F0F);
		check(n_ks, 2);
		check(n_rs, 1);
	endtask

	task automatic t_refuse();
		n_wr = 0;
		img(1'b0, 1'b1, 1'b0, 1'b0, 32'h00000001, 1'b1, 1);
		check(image_error_q, 1'b1);
		img(1'b0, 1'b0, 1'b1, 1'b0, 32'h00000001, 1'b0, 1);
		check(image_error_q, 1'b1);
		img(1'b0, 1'b0, 1'b0, 1'b0, 32'h00000077, 1'b0, 1);
		repeat (8) @(posedge clk);
		check(n_wr, 1);
		check({image_error_q, last_cfg}, {1'b0, 1'b0, 1'b0, 32'h00000077});
	endtask

	task automatic t_cfg_off();
		link_based_configuration_en <= 1'b0;
		done_pin_user_out <= 1'b1;
		done_pin_user_oe <= 1'b1;
		done_pin_in <= 1'b1;
		repeat (3) @(posedge clk);
		check({fabric_config_done_out, fabric_config_done_oe, done_pin_user_in_q}, 3'h7);
		done_pin_user_oe <= 1'b0;
		done_pin_in <= 1'b0;
		repeat (3) @(posedge clk);
		check({fabric_config_done_out, fabric_config_done_oe, done_pin_user_in_q}, 3'h4);
		img(1'b1, 1'b0, 1'b0, 1'b0, 32'h00000001, 1'b0, 1);
		check(image_error_q, 1'b1);
		link_based_configuration_en <= 1'b1;
		done_pin_in <= 1'b1;
		repeat (3) @(posedge clk);
		check({fabric_config_done_oe, done_pin_user_in_q}, 2'b10);
	endtask

	task automatic t_reset_pin();
		// reset pin drops mid image: load aborts, done stays low
		i_host.send(lfcs_word_t'{sop: 1'b1, fabric: 1'b1, default: '0});
		i_host.idle();
		i_host.set_rst(1'b0);
		repeat (2) @(posedge clk);
		check({xcvr_reset_q, hard_block_reset_q}, 2'b11);
		check({image_error_q, fabric_config_done_q}, 2'b10);
		i_host.set_rst(1'b1);
		repeat (2) @(posedge clk);
		check({xcvr_reset_q, hard_block_reset_q}, 2'b00);
		hard_block_used <= 1'b0;
		repeat (3) @(posedge clk);
		check({user_reset_pin_q, xcvr_reset_q}, 2'b11);
		i_host.set_rst(1'b0);
		repeat (2) @(posedge clk);
		check(user_reset_pin_q, 1'b0);
	endtask

	initial begin
		srst = 1'b1;
		link_based_configuration_en = 1'b1;
		hard_block_used = 1'b1;
		cipher_ks_valid = 1'b1;
		cipher_ks = 32'h0;
		done_pin_user_out = 1'b0;
		done_pin_user_oe = 1'b0;
		done_pin_in = 1'b0;
		wr_done = 1'b0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		check({xcvr_reset_q, fabric_config_done_q}, 2'b10);
		while (link_fundamental_reset_n !== 1'b1) @(posedge clk);
		repeat (2) @(posedge clk);
		check(xcvr_reset_q, 1'b0);
		t_plain();
		t_partial();
		t_compress();
		t_encrypt();
		t_refuse();
		t_cfg_off();
		t_reset_pin();
		complete_run();
	end
endmodule
`default_nettype wire
